// ### hw/cpm_consts.svh
// Constants of the codec port mode pin multiplexer and its adaptive clock generator.
`ifndef CPM_CONSTS_SVH
`define CPM_CONSTS_SVH

// ----------------------------------------------------------------------------
// Mode codes of the mode-select field
// ----------------------------------------------------------------------------
`define CPM_MODE_W 3
`define CPM_MODE_GP 3'h0
`define CPM_MODE_FSTROBE 3'h1
`define CPM_MODE_AC97_V1 3'h2
`define CPM_MODE_AC97_V2 3'h3
`define CPM_MODE_I2S_A 3'h4
`define CPM_MODE_I2S_B 3'h5

// ----------------------------------------------------------------------------
// Adaptive clock generator
// ----------------------------------------------------------------------------
`define CPM_ACC_W 24
`define CPM_INC_RESET 24'h2c0000
`define CPM_CNT_W 16
`define CPM_CNT_MAX 16'hffff

// ----------------------------------------------------------------------------
// Port clock dividers
// ----------------------------------------------------------------------------
`define CPM_DIV_W 4
`define CPM_SCLK_HALF 4'h1
`define CPM_FS_W 6
`define CPM_FS_HALF 6'h1f

`endif

// ### hw/cpm_pinmux.sv
// Codec port mode pin multiplexer with adaptive master clock generator.
`timescale 1ns/10ps
`include "cpm_consts.svh"

// Function
// - Mode-select field sets all six pin roles.
// - Mode 0: sync/clock programmable, others fixed.
// - Functionless pins are still driven outputs.
// - Mode 2: clock and data in from codec.
// - Mode 3: clock in, two input streams.
// - Mode 4: word-select, clock out, two inputs.
// - Mode 5: second clock, word-select on pins.
// - Count master clocks between start-of-frame events.
// - Firmware corrections steer the master clock rate.
// - External master clock may source port clocks.
// - Port clocks come only from master clock.
module cpm_pinmux (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Configuration
  input wire cpm_pkg::cpm_code_t i_codec_port_config_one_mode,
  input wire logic i_gp_frame_sync_drive,
  input wire logic i_gp_serial_clock_drive,
  input wire logic i_external_clock_select,
  // Adaptive clock generator control
  input wire logic i_sof,
  input wire logic i_acg_correction_valid,
  input wire logic [`CPM_ACC_W-1:0] i_acg_increment,
  // Port engine side
  input wire logic i_serial_data_out,
  input wire logic i_codec_reset_n,
  input wire logic i_secondary_frame_flag,
  // Pin inputs
  input wire logic i_external_master_clock_in,
  input wire logic i_codec_frame_sync_pin_in,
  input wire logic i_codec_serial_clock_pin_in,
  input wire logic i_codec_data_in_pin_in,
  input wire logic i_codec_auxiliary_pin_in,
  // Pin outputs
  output logic o_codec_frame_sync_pin_out,
  output logic o_codec_frame_sync_pin_oe,
  output logic o_codec_serial_clock_pin_out,
  output logic o_codec_serial_clock_pin_oe,
  output logic o_codec_data_out_pin_out,
  output logic o_codec_data_out_pin_oe,
  output logic o_codec_data_in_pin_out,
  output logic o_codec_data_in_pin_oe,
  output logic o_codec_reset_pin_out,
  output logic o_codec_reset_pin_oe,
  output logic o_codec_auxiliary_pin_out,
  output logic o_codec_auxiliary_pin_oe,
  output logic o_adaptive_master_clock_out,
  // Status and received data
  output logic [`CPM_CNT_W-1:0] o_acg_frame_count,
  output logic o_acg_count_valid,
  output logic o_serial_clock_rise,
  output logic o_serial_clock_fall,
  output logic o_frame_sync_level,
  output logic o_serial_data_in,
  output logic o_second_serial_data_in
);
  import cpm_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic cpm_mode_e decode_mode(input cpm_code_t code);
    case (code)
      `CPM_MODE_GP: decode_mode = CPM_M_GP;
      `CPM_MODE_FSTROBE: decode_mode = CPM_M_FSTROBE;
      `CPM_MODE_AC97_V1: decode_mode = CPM_M_AC97_V1;
      `CPM_MODE_AC97_V2: decode_mode = CPM_M_AC97_V2;
      `CPM_MODE_I2S_A: decode_mode = CPM_M_I2S_A;
      `CPM_MODE_I2S_B: decode_mode = CPM_M_I2S_B;
      default: decode_mode = CPM_M_UNUSED;
    endcase
  endfunction

  localparam int P_FS = 0;
  localparam int P_SC = 1;
  localparam int P_DO = 2;
  localparam int P_DI = 3;
  localparam int P_RS = 4;
  localparam int P_AX = 5;

  cpm_state_s st_r;
  cpm_state_s st_nxt;
  cpm_mode_e mode;
  logic master_edge;
  logic [`CPM_ACC_W-1:0] acc_sum;
  logic clk_pin_in;
  logic clk_level;

  assign mode = decode_mode(i_codec_port_config_one_mode);
  assign acc_sum = st_r.acc + st_r.inc;
  assign master_edge = i_external_clock_select ? (st_r.mclk_s2 & ~st_r.mclk_prev)
                                               : (st_r.acc[`CPM_ACC_W-1] & ~st_r.nco_prev);
  // The serial clock is taken from the pin whenever the pin is not driven by us.
  assign clk_pin_in = (mode == CPM_M_AC97_V1) || (mode == CPM_M_AC97_V2) ||
                      ((mode == CPM_M_GP) && !i_gp_serial_clock_drive);
  assign clk_level = clk_pin_in ? st_r.sclk_s2 : st_r.sclk_int;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.mclk_s1 = i_external_master_clock_in;
    st_nxt.mclk_s2 = st_r.mclk_s1;
    st_nxt.mclk_prev = st_r.mclk_s2;
    st_nxt.sclk_s1 = i_codec_serial_clock_pin_in;
    st_nxt.sclk_s2 = st_r.sclk_s1;
    st_nxt.sclk_prev = clk_level;
    st_nxt.fsync_s1 = i_codec_frame_sync_pin_in;
    st_nxt.fsync_s2 = st_r.fsync_s1;
    st_nxt.din_s1 = i_codec_data_in_pin_in;
    st_nxt.din_s2 = st_r.din_s1;
    st_nxt.aux_s1 = i_codec_auxiliary_pin_in;
    st_nxt.aux_s2 = st_r.aux_s1;
    // The accumulator MSB is a square wave whose rate follows the increment.
    st_nxt.acc = acc_sum;
    st_nxt.nco_prev = st_r.acc[`CPM_ACC_W-1];
    st_nxt.mclk_out = st_r.acc[`CPM_ACC_W-1];
    if (i_acg_correction_valid) begin
      st_nxt.inc = i_acg_increment;
    end
    // Counts saturate so a lost frame event cannot wrap into a plausible value.
    st_nxt.count_valid = 1'b0;
    if (i_sof) begin
      st_nxt.frame_count = st_r.edge_cnt;
      st_nxt.count_valid = 1'b1;
      st_nxt.edge_cnt = {{(`CPM_CNT_W-1){1'b0}}, master_edge};
    end else if (master_edge && st_r.edge_cnt != `CPM_CNT_MAX) begin
      st_nxt.edge_cnt = st_r.edge_cnt + 1'b1;
    end
    if (master_edge) begin
      if (st_r.div_cnt == `CPM_SCLK_HALF) begin
        st_nxt.div_cnt = '0;
        st_nxt.sclk_int = ~st_r.sclk_int;
        if (st_r.sclk_int) begin
          if (st_r.fs_cnt == `CPM_FS_HALF) begin
            st_nxt.fs_cnt = '0;
            st_nxt.fs_int = ~st_r.fs_int;
          end else begin
            st_nxt.fs_cnt = st_r.fs_cnt + 1'b1;
          end
        end
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 1'b1;
      end
    end
    st_nxt.clk_rise = clk_level & ~st_r.sclk_prev;
    st_nxt.clk_fall = ~clk_level & st_r.sclk_prev;
    // Pin roles; the default drives every pin as an output, with the data-in and auxiliary pins low.
    st_nxt.pin_oe = 6'h3f;
    st_nxt.pin_out = 6'h00;
    st_nxt.pin_out[P_FS] = st_r.fs_int;
    st_nxt.pin_out[P_SC] = st_r.sclk_int;
    st_nxt.pin_out[P_DO] = i_serial_data_out;
    st_nxt.pin_out[P_RS] = i_codec_reset_n;
    case (mode)
      CPM_M_GP: begin
        st_nxt.pin_oe[P_FS] = i_gp_frame_sync_drive;
        st_nxt.pin_oe[P_SC] = i_gp_serial_clock_drive;
        st_nxt.pin_oe[P_DI] = 1'b0;
      end
      CPM_M_FSTROBE: begin
        st_nxt.pin_oe[P_DI] = 1'b0;
        st_nxt.pin_out[P_AX] = i_secondary_frame_flag;
      end
      CPM_M_AC97_V1: begin
        st_nxt.pin_oe[P_SC] = 1'b0;
        st_nxt.pin_oe[P_DI] = 1'b0;
      end
      CPM_M_AC97_V2: begin
        st_nxt.pin_oe[P_SC] = 1'b0;
        st_nxt.pin_oe[P_DI] = 1'b0;
        st_nxt.pin_oe[P_AX] = 1'b0;
      end
      CPM_M_I2S_A: begin
        st_nxt.pin_oe[P_DI] = 1'b0;
        st_nxt.pin_oe[P_AX] = 1'b0;
      end
      CPM_M_I2S_B: begin
        st_nxt.pin_oe[P_DI] = 1'b0;
        st_nxt.pin_out[P_RS] = st_r.sclk_int;
        st_nxt.pin_out[P_AX] = st_r.fs_int;
      end
      default: begin
        // Every role is masked so that an unused code cannot leak a clock or data level onto a pin.
        st_nxt.pin_out = 6'h00;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_r <= '0;
      st_r.inc <= `CPM_INC_RESET;
      st_r.pin_oe <= 6'h3f;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_codec_frame_sync_pin_out = st_r.pin_out[P_FS];
  assign o_codec_frame_sync_pin_oe = st_r.pin_oe[P_FS];
  assign o_codec_serial_clock_pin_out = st_r.pin_out[P_SC];
  assign o_codec_serial_clock_pin_oe = st_r.pin_oe[P_SC];
  assign o_codec_data_out_pin_out = st_r.pin_out[P_DO];
  assign o_codec_data_out_pin_oe = st_r.pin_oe[P_DO];
  assign o_codec_data_in_pin_out = st_r.pin_out[P_DI];
  assign o_codec_data_in_pin_oe = st_r.pin_oe[P_DI];
  assign o_codec_reset_pin_out = st_r.pin_out[P_RS];
  assign o_codec_reset_pin_oe = st_r.pin_oe[P_RS];
  assign o_codec_auxiliary_pin_out = st_r.pin_out[P_AX];
  assign o_codec_auxiliary_pin_oe = st_r.pin_oe[P_AX];
  assign o_adaptive_master_clock_out = st_r.mclk_out;
  assign o_acg_frame_count = st_r.frame_count;
  assign o_acg_count_valid = st_r.count_valid;
  assign o_serial_clock_rise = st_r.clk_rise;
  assign o_serial_clock_fall = st_r.clk_fall;
  assign o_frame_sync_level = st_r.fsync_s2;
  assign o_serial_data_in = st_r.din_s2;
  assign o_second_serial_data_in = st_r.aux_s2;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // Mode antecedents other than AST_UNUSED_DRIVEN also need reset released, because pin roles lag the release by one cycle.
  AST_UNUSED_DRIVEN: assert property (@(posedge i_clk) disable iff (!i_resetn)
    mode == CPM_M_UNUSED |=> st_r.pin_oe == 6'h3f && st_r.pin_out == 6'h00)
    else $error("unused mode left a pin undriven or high");
  AST_GP_DIRECTION: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_resetn && mode == CPM_M_GP |=> o_codec_frame_sync_pin_oe == $past(i_gp_frame_sync_drive) &&
      o_codec_serial_clock_pin_oe == $past(i_gp_serial_clock_drive) && o_codec_auxiliary_pin_oe)
    else $error("general mode pin direction wrong");
  AST_DATA_IN_INPUT: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_resetn && mode != CPM_M_UNUSED |=> !o_codec_data_in_pin_oe && o_codec_data_out_pin_oe)
    else $error("data pins have wrong direction");
  AST_AC97_CLOCK_IN: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_resetn && (mode == CPM_M_AC97_V1 || mode == CPM_M_AC97_V2) |=> !o_codec_serial_clock_pin_oe &&
      o_codec_frame_sync_pin_oe)
    else $error("link clock pin driven in link-clocked mode");
  AST_AUX_STREAM_IN: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_resetn && (mode == CPM_M_AC97_V2 || mode == CPM_M_I2S_A) |=> !o_codec_auxiliary_pin_oe)
    else $error("second input stream pin is driven");
  AST_SECOND_PAIR: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_resetn && mode == CPM_M_I2S_B |=> o_codec_auxiliary_pin_out == $past(st_r.fs_int) &&
      o_codec_reset_pin_out == $past(st_r.sclk_int) && o_codec_auxiliary_pin_oe)
    else $error("second clock pair not on reset and auxiliary pins");
  AST_FRAME_FLAG: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_resetn && mode == CPM_M_FSTROBE |=> o_codec_auxiliary_pin_out == $past(i_secondary_frame_flag))
    else $error("secondary frame flag not on auxiliary pin");
  AST_FRAME_COUNT: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_sof |=> o_acg_count_valid && o_acg_frame_count == $past(st_r.edge_cnt) ##1
      (o_acg_count_valid == $past(i_sof)))
    else $error("frame count not captured at start of frame");
  AST_CORRECTION: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_acg_correction_valid |=> st_r.inc == $past(i_acg_increment) ##1
      st_r.acc == $past(st_r.acc) + $past(i_acg_increment, 2))
    else $error("correction not applied to generator");
  AST_DIVIDER_SOURCE: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !master_edge |=> $stable(st_r.div_cnt) && $stable(st_r.sclk_int))
    else $error("port clock advanced without a master clock edge");

endmodule

// ### hw/cpm_pkg.sv
// Types of the codec port mode pin multiplexer.
`include "cpm_consts.svh"
package cpm_pkg;

  typedef enum logic [6:0] {
    CPM_M_GP      = 7'h01,
    CPM_M_FSTROBE = 7'h02,
    CPM_M_AC97_V1 = 7'h04,
    CPM_M_AC97_V2 = 7'h08,
    CPM_M_I2S_A   = 7'h10,
    CPM_M_I2S_B   = 7'h20,
    CPM_M_UNUSED  = 7'h40
  } cpm_mode_e;

  typedef logic [`CPM_MODE_W-1:0] cpm_code_t;

  typedef struct packed {
    logic mclk_s1;
    logic mclk_s2;
    logic mclk_prev;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_prev;
    logic fsync_s1;
    logic fsync_s2;
    logic din_s1;
    logic din_s2;
    logic aux_s1;
    logic aux_s2;
    logic [`CPM_ACC_W-1:0] acc;
    logic [`CPM_ACC_W-1:0] inc;
    logic nco_prev;
    logic mclk_out;
    logic [`CPM_CNT_W-1:0] edge_cnt;
    logic [`CPM_CNT_W-1:0] frame_count;
    logic count_valid;
    logic [`CPM_DIV_W-1:0] div_cnt;
    logic sclk_int;
    logic [`CPM_FS_W-1:0] fs_cnt;
    logic fs_int;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic clk_rise;
    logic clk_fall;
  } cpm_state_s;

endpackage

// ### verif/cpm_codec_model.sv
// Behavioural model of the external codec facing the codec port pins.
`timescale 1ns/10ps
module cpm_codec_model (
  // Codec controls from the bench
  input wire logic i_bclk_run,
  input wire logic i_mclk_run,
  input wire logic i_sd1,
  input wire logic i_sd2,
  // Device pin drivers, order frame sync, serial clock, data out, data in, reset, auxiliary
  input wire logic [5:0] i_dev_out,
  input wire logic [5:0] i_dev_oe,
  // Resolved pin levels
  output logic o_mclk,
  output logic o_fs,
  output logic o_sc,
  output logic o_di,
  output logic o_aux
);
  logic bclk;
  logic mclk;

  // --------------------------------------------------------------------------
  // Codec clocks
  // --------------------------------------------------------------------------
  // Both clocks stand low while stopped, so a design that counts edges on an idle wire fails.
  initial begin
    bclk = 1'b0;
    #11;
    forever #160 bclk = i_bclk_run ? ~bclk : 1'b0;
  end

  initial begin
    mclk = 1'b0;
    #7;
    forever #160 mclk = i_mclk_run ? ~mclk : 1'b0;
  end

  // --------------------------------------------------------------------------
  // Wire resolution
  // --------------------------------------------------------------------------
  // The device wins where it drives; elsewhere the codec drives its own level.
  assign o_mclk = mclk;
  assign o_fs = i_dev_oe[5] ? i_dev_out[5] : 1'b1;
  assign o_sc = i_dev_oe[4] ? i_dev_out[4] : bclk;
  assign o_di = i_dev_oe[2] ? i_dev_out[2] : i_sd1;
  assign o_aux = i_dev_oe[0] ? i_dev_out[0] : i_sd2;
endmodule

// ### verif/tb.sv
// Self-checking testbench of the codec port pin multiplexer.
`timescale 1ns/10ps
`include "cpm_consts.svh"
module tb;
  import cpm_pkg::*;
  logic clk, resetn, gp_fs, gp_sc, ext_sel, sof, cv, sdo, crst_n, flag;
  logic bclk_run, mclk_run, sd1, sd2, mclk_p, fs_p, sc_p, di_p, aux_p;
  logic cnt_v, sc_rise, sc_fall, fs_lvl, sdi, sdi2, mclk_o;
  cpm_code_t mode;
  logic [`CPM_ACC_W-1:0] inc;
  logic [`CPM_CNT_W-1:0] cnt;
  logic [5:0] pout, poe;
  int n_mismatch, checks;

  cpm_pinmux dut_u (.i_clk(clk), .i_resetn(resetn), .i_codec_port_config_one_mode(mode),
    .i_gp_frame_sync_drive(gp_fs), .i_gp_serial_clock_drive(gp_sc), .i_external_clock_select(ext_sel),
    .i_sof(sof), .i_acg_correction_valid(cv), .i_acg_increment(inc), .i_serial_data_out(sdo),
    .i_codec_reset_n(crst_n), .i_secondary_frame_flag(flag), .i_external_master_clock_in(mclk_p),
    .i_codec_frame_sync_pin_in(fs_p), .i_codec_serial_clock_pin_in(sc_p), .i_codec_data_in_pin_in(di_p),
    .i_codec_auxiliary_pin_in(aux_p), .o_codec_frame_sync_pin_out(pout[5]), .o_codec_frame_sync_pin_oe(poe[5]),
    .o_codec_serial_clock_pin_out(pout[4]), .o_codec_serial_clock_pin_oe(poe[4]),
    .o_codec_data_out_pin_out(pout[3]), .o_codec_data_out_pin_oe(poe[3]),
    .o_codec_data_in_pin_out(pout[2]), .o_codec_data_in_pin_oe(poe[2]),
    .o_codec_reset_pin_out(pout[1]), .o_codec_reset_pin_oe(poe[1]),
    .o_codec_auxiliary_pin_out(pout[0]), .o_codec_auxiliary_pin_oe(poe[0]),
    .o_adaptive_master_clock_out(mclk_o), .o_acg_frame_count(cnt), .o_acg_count_valid(cnt_v),
    .o_serial_clock_rise(sc_rise), .o_serial_clock_fall(sc_fall), .o_frame_sync_level(fs_lvl),
    .o_serial_data_in(sdi), .o_second_serial_data_in(sdi2));

  cpm_codec_model codec_u (.i_bclk_run(bclk_run), .i_mclk_run(mclk_run), .i_sd1(sd1), .i_sd2(sd2),
    .i_dev_out(pout), .i_dev_oe(poe), .o_mclk(mclk_p), .o_fs(fs_p), .o_sc(sc_p), .o_di(di_p), .o_aux(aux_p));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse_sof;
    @(posedge clk) sof <= 1'b1;
    @(posedge clk) sof <= 1'b0;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_modes;
    logic [5:0] exp_oe [8] = '{6'h3b, 6'h3b, 6'h2b, 6'h2a, 6'h3a, 6'h3b, 6'h3f, 6'h3f};
    for (int m = 0; m < 8; m++) begin
      @(posedge clk) mode <= m[2:0];
      cyc(2);
      @(negedge clk);
      check("pin_oe", 16'(poe), 16'(exp_oe[m]));
      check("data_out", 16'(pout[3]), 16'(m < 6));
      if (m != 5) check("reset_pin", 16'(pout[1]), 16'(m < 5));
      if (m < 3 || m > 5) check("aux_out", 16'(pout[0]), 16'(m == 1));
      if (m > 5) check("pin_out", 16'(pout), 16'h0000);
    end
    @(posedge clk) begin mode <= 3'h0; gp_fs <= 1'b0; gp_sc <= 1'b0; end
    cyc(2);
    @(negedge clk);
    check("gp_oe", 16'(poe), 16'h000b);
    cyc(1);
    @(negedge clk);
    check("fs_level", 16'(fs_lvl), 16'h0001);
    @(posedge clk) gp_fs <= 1'b1;
    cyc(2);
    @(negedge clk);
    check("gp_oe", 16'(poe), 16'h002b);
    @(posedge clk) begin mode <= 3'h1; flag <= 1'b0; end
    cyc(2);
    @(negedge clk);
    check("aux_flag", 16'(pout[0]), 16'h0000);
    $display("t_modes done");
  endtask

  task automatic t_inputs;
    for (int m = 3; m < 5; m++) for (int v = 0; v < 2; v++) begin
      @(posedge clk) begin mode <= m[2:0]; sd1 <= v[0]; sd2 <= !v[0]; end
      cyc(4);
      @(negedge clk);
      check("sd_in", 16'(sdi), 16'(v[0]));
      check("sd_in2", 16'(sdi2), 16'(!v[0]));
    end
    $display("t_inputs done");
  endtask

  task automatic t_bclk;
    int nr = 0;
    int nf = 0;
    @(posedge clk) begin mode <= 3'h2; bclk_run <= 1'b1; end
    cyc(20);
    repeat (80) begin
      @(negedge clk);
      nr += sc_rise;
      nf += sc_fall;
    end
    check("bclk_rise", 16'(nr), 16'h000a);
    check("bclk_fall", 16'(nf), 16'h000a);
    @(posedge clk) bclk_run <= 1'b0;
    $display("t_bclk done");
  endtask

  // Two start-of-frame events 96 cycles apart; the master period divides 96 exactly.
  task automatic t_count(input logic [23:0] incv, input logic sel, input logic [15:0] exp);
    int k = 0;
    @(posedge clk) begin cv <= 1'b1; inc <= incv; ext_sel <= sel; end
    @(posedge clk) cv <= 1'b0;
    cyc(10);
    pulse_sof;
    cyc(94);
    pulse_sof;
    @(negedge clk);
    while (cnt_v !== 1'b1 && k < 3) begin
      @(negedge clk);
      k++;
    end
    check("count_valid", 16'(cnt_v), 16'h0001);
    check("frame_count", cnt, exp);
    @(negedge clk);
    check("valid_pulse", 16'(cnt_v), 16'h0000);
    $display("t_count done");
  endtask

  task automatic t_sclk(input logic [15:0] exp);
    int n = 0;
    int nm = 0;
    logic prev;
    logic mprev;
    @(posedge clk) mode <= 3'h4;
    cyc(40);
    @(negedge clk);
    prev = pout[4];
    mprev = mclk_o;
    repeat (128) begin
      @(negedge clk);
      n += (pout[4] && !prev);
      prev = pout[4];
      nm += (mclk_o && !mprev);
      mprev = mclk_o;
    end
    check("sclk_rises", 16'(n), exp);
    check("mclk_rises", 16'(nm), 16'h0020);
    $display("t_sclk done");
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    resetn = 1'b0; mode = 3'h0; gp_fs = 1'b1; gp_sc = 1'b1; ext_sel = 1'b0; sof = 1'b0;
    cv = 1'b0; inc = '0; sdo = 1'b1; crst_n = 1'b1; flag = 1'b1;
    bclk_run = 1'b0; mclk_run = 1'b0; sd1 = 1'b0; sd2 = 1'b0;
    cyc(3);
    @(negedge clk);
    check("reset_oe", 16'(poe), 16'h003f);
    cyc(1);
    resetn <= 1'b1;
    t_modes;
    t_inputs;
    t_bclk;
    t_count(24'h200000, 1'b0, 16'h000c);
    t_count(24'h400000, 1'b0, 16'h0018);
    t_sclk(16'h0008);
    @(posedge clk) mclk_run <= 1'b1;
    t_count(24'h400000, 1'b1, 16'h000c);
    t_sclk(16'h0004);
    test_done;
  end

  // A hang is cut short here and counted as a mismatch.
  initial begin
    #2000000;
    n_mismatch++;
    test_done;
  end
endmodule
